// ===== far_side_model.sv
// Purpose: far side of the sequencer: pixel hold stages of the array and the video receiver
// Assumes: held levels are coded from row and column so the bench can predict every word
// Notes:   with no row selected the level lines change every cycle, never a stale value
`timescale 1ns/1ns
module far_side_model #(
  parameter int DW = 12,
  parameter int RB = 2,
  parameter int CB = 4
) (
  input  wire logic          clk_in,          // core clock
  input  wire logic          rst_n_in,        // reset, active low
  input  wire logic [RB-1:0] row_in,          // selected row
  input  wire logic          row_valid_in,    // a row is selected
  input  wire logic [CB-1:0] col_in,          // selected column
  input  wire logic          stall_in,        // hold ready low
  input  wire logic          slow_in,         // ready every other cycle
  input  wire logic [DW-1:0] video_signal_in, // received signal level
  input  wire logic [DW-1:0] video_reset_in,  // received reset level
  output logic      [DW-1:0] pix_signal_out,  // held signal level
  output logic      [DW-1:0] pix_reset_out,   // held reset level
  output logic               ready_out,       // receiver accepts
  output logic      [DW-1:0] offset_free_out  // signal minus reset level
);
  logic [DW-1:0] idle_reg;
  logic          phase_reg;
  logic          ready_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_reg  <= '0;
      phase_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      idle_reg  <= ~idle_reg;
      phase_reg <= ~phase_reg;
      ready_reg <= !stall_in && (!slow_in || phase_reg);
    end
  end

  always_comb begin
    if (row_valid_in) begin
      pix_signal_out = DW'(12'h500) + DW'({row_in, col_in});
      pix_reset_out  = DW'(12'h200) + DW'({row_in, col_in});
    end else begin
      pix_signal_out = idle_reg;
      pix_reset_out  = ~idle_reg;
    end
  end

  assign ready_out       = ready_reg;
  // receiver removes the per-pixel offset
  assign offset_free_out = video_signal_in - video_reset_in;
endmodule

// ===== pixel_fifo.sv
// Purpose: word FIFO between the column scan and the video output
// Assumes: one clock, valid/ready on both sides
// Notes:   full drops in_ready, which stalls the column scan
`timescale 1ns/1ns
module pixel_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,    // core clock
  input  wire logic             rst_n_in,  // synchronised reset
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // not full
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // not empty
  input  wire logic             out_ready, // read accept
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("pixel_fifo: DEPTH must be a power of two >= 2");
  end

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_next  = push ? wr_reg + AW'(1) : wr_reg;
    rd_next  = pop ? rd_reg + AW'(1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

// ===== scan_seq_pkg.sv
// Purpose: shared constants and types of the area sensor scan sequencer
// Assumes: core clock of 250 MHz stands in for the master clock
// Notes:   slot, phase and low times kept in cycles; row blank kept in ns, its cycle count derived from the clock period
package scan_seq_pkg;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int ARRAY_ROWS     = 128;
  localparam int ARRAY_COLS     = 128;
  localparam int FRAME_PIXELS   = ARRAY_ROWS * ARRAY_COLS;
  localparam int SLOT_CYC       = 4;
  localparam int PHASE_CYC      = 4;
  localparam int MIN_LOW_CYC    = 20;
  localparam int ROW_BLANK_NS   = 4600;
  localparam int ROW_BLANK_CYC  = (ROW_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIX_DW         = 12;
  localparam int FIFO_DEPTH     = 8;
  localparam logic [1:0] MODE_ROLLING = 2'h0;
  localparam logic [1:0] MODE_GLOBAL  = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GCAP,
    ST_SIG,
    ST_RST,
    ST_RHOLD,
    ST_SCAN,
    ST_BLANK
  } seq_state_e;
endpackage

// ===== scan_sequencer.sv
// Purpose: row/column scan sequencer and video serialiser of a 128x128 readout_circuit
// Assumes: frame_start_pulse and mode inputs synchronous to the core clock
// Notes:   each core clock edge stands for a falling master clock edge
//
// Operation
// - rolling mode keeps every pixel sample-and-hold switch closed
// - rows selected one at a time, top to bottom, full sequence per row
// - first phase transfers the pixel level and captures it as signal
// - then pixel reset, reset level captured in a second hold
// - columns scanned in order, emitting signal and reset level serially
// - rolling mode: row reset released and row advanced once readout ends
// - frame starts on the edge after frame_start_pulse rises, after last row
// - rolling integration runs from row release to its next signal capture
// - global integration equals the frame_start_pulse low interval
// - global mode captures all pixels at once, then reads rows in order
// - global readout transfers the in-pixel held value, then reset and output
// - global mode releases all pixel resets when the pulse falls after frame
// - array is 128 rows by 128 columns, 16384 pixels
// - each pixel slot lasts four clock cycles in which the buffer has room
`timescale 1ns/1ns
module scan_sequencer import scan_seq_pkg::*; #(
  parameter int ROWS  = ARRAY_ROWS,
  parameter int COLS  = ARRAY_COLS,
  parameter int DW    = PIX_DW,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                        CORE_CLK_IN,             // core clock
  input  wire logic                        RESETN_IN,               // async reset, active low
  input  wire logic                        FRAME_START_PULSE_IN,    // frame start, a rise in idle starts a scan
  input  wire logic                        MODE1_IN,                // mode select 1
  input  wire logic                        MODE2_IN,                // mode select 2
  input  wire logic [DW-1:0]               PIX_SIGNAL_IN,           // held signal level of column
  input  wire logic [DW-1:0]               PIX_RESET_IN,            // held reset level of column
  input  wire logic                        VIDEO_READY_IN,          // receiver accepts word
  output logic      [$clog2(ROWS)-1:0]     ROW_SEL_OUT,             // selected row
  output logic                             ROW_SEL_VALID_OUT,       // a row is selected
  output logic      [$clog2(COLS)-1:0]     COL_SEL_OUT,             // selected column
  output logic                             SIG_HOLD_OUT,            // capture signal level
  output logic                             RST_HOLD_OUT,            // capture reset level
  output logic                             ROW_RESET_OUT,           // selected row reset switch
  output logic                             ALL_RESET_OUT,           // all-pixel reset switch
  output logic                             PIXEL_SH_CLOSED_OUT,     // in-pixel sample-hold closed
  output logic                             GLOBAL_CAPTURE_OUT,      // all-pixel capture
  output logic                             FRAME_BUSY_OUT,          // frame scan in progress
  output logic                             VIDEO_VALID_OUT,         // video word valid
  output logic      [DW-1:0]               VIDEO_SIGNAL_OUT,        // signal level
  output logic      [DW-1:0]               VIDEO_RESET_OUT,         // reset level
  output logic                             CONVERTER_SAMPLE_STROBE_OUT // converter samples now
);
  localparam int RW = $clog2(ROWS);
  localparam int CW = $clog2(COLS);
  localparam int BW = $clog2(ROW_BLANK_CYC + 1);

  initial begin
    if (ROWS < 2 || COLS < 2 || DW < 1) $error("scan_sequencer: bad array geometry");
    if (ROWS * COLS != FRAME_PIXELS && ROWS == ARRAY_ROWS) $error("scan_sequencer: bad pixel count");
  end

  logic             rst_s1_reg;
  logic             rst_n;
  logic             msp_d_reg;
  logic             msp_rise;
  seq_state_e       state_reg;
  seq_state_e       state_next;
  logic [RW-1:0]    row_reg;
  logic [RW-1:0]    row_next;
  logic [CW-1:0]    col_reg;
  logic [CW-1:0]    col_next;
  logic [BW-1:0]    cnt_reg;
  logic [BW-1:0]    cnt_next;
  logic             global_reg;
  logic             global_next;
  logic             all_rst_reg;
  logic             all_rst_next;
  logic             sh_reg;
  logic             sh_next;
  logic             mode_global_live;
  logic             slot_tick;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [2*DW-1:0]  fifo_out_data;
  logic             push;
  logic             pop;
  logic             vvalid_reg;
  logic             vvalid_next;
  logic [DW-1:0]    vsig_reg;
  logic [DW-1:0]    vrst_reg;

  function automatic logic phase_done(input logic [BW-1:0] c, input int len);
    return c == BW'(len - 1);
  endfunction

  // reset released through two flops
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  assign msp_rise         = FRAME_START_PULSE_IN && !msp_d_reg;
  assign mode_global_live = ({MODE2_IN, MODE1_IN} == MODE_GLOBAL);
  assign push             = slot_tick;

  slot_divider #(.DIV(SLOT_CYC)) u_div (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (rst_n),
    .run_in   (state_reg == ST_SCAN),
    .en_in    (fifo_in_ready),
    .tick_out (slot_tick)
  );

  pixel_fifo #(.WIDTH(2*DW), .DEPTH(DEPTH)) u_fifo (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({PIX_SIGNAL_IN, PIX_RESET_IN}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    state_next   = state_reg;
    row_next     = row_reg;
    col_next     = col_reg;
    cnt_next     = cnt_reg + BW'(1);
    global_next  = global_reg;
    all_rst_next = all_rst_reg;
    sh_next      = sh_reg;
    unique case (state_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (mode_global_live && !FRAME_START_PULSE_IN) begin
          all_rst_next = 1'b0;
          sh_next      = 1'b1;
        end
        if (!mode_global_live) begin
          sh_next = 1'b1;
        end
        if (msp_rise) begin
          row_next    = '0;
          col_next    = '0;
          global_next = mode_global_live;
          state_next  = mode_global_live ? ST_GCAP : ST_SIG;
        end
      end
      ST_GCAP: begin
        if (phase_done(cnt_reg, PHASE_CYC)) begin
          sh_next      = 1'b0;
          all_rst_next = 1'b1;
          cnt_next     = '0;
          state_next   = ST_SIG;
        end
      end
      ST_SIG: begin
        if (phase_done(cnt_reg, PHASE_CYC)) begin
          cnt_next   = '0;
          state_next = ST_RST;
        end
      end
      ST_RST: begin
        if (phase_done(cnt_reg, PHASE_CYC)) begin
          cnt_next   = '0;
          state_next = ST_RHOLD;
        end
      end
      ST_RHOLD: begin
        if (phase_done(cnt_reg, PHASE_CYC)) begin
          cnt_next   = '0;
          col_next   = '0;
          state_next = ST_SCAN;
        end
      end
      ST_SCAN: begin
        cnt_next = '0;
        if (slot_tick) begin
          col_next = col_reg + CW'(1);
          if (col_reg == CW'(COLS - 1)) begin
            // wrap explicitly so a column count that is not a power of two still ends the row
            col_next   = '0;
            state_next = ST_BLANK;
            if (row_reg != RW'(ROWS - 1)) begin
              row_next = row_reg + RW'(1);
            end
          end
        end
      end
      ST_BLANK: begin
        if (phase_done(cnt_reg, ROW_BLANK_CYC)) begin
          cnt_next = '0;
          if (row_reg == RW'(ROWS - 1) && col_reg == '0 && ROW_SEL_VALID_OUT == 1'b0) begin
            state_next = ST_IDLE;
          end else begin
            state_next = ST_SIG;
          end
        end
      end
    endcase
  end

  // last row is marked by holding the row index and clearing the row-valid flag
  logic rowv_reg;
  logic rowv_next;
  always_comb begin
    rowv_next = rowv_reg;
    if (state_reg == ST_IDLE && msp_rise) begin
      rowv_next = 1'b1;
    end else if (state_reg == ST_SCAN && slot_tick && col_reg == CW'(COLS - 1) && row_reg == RW'(ROWS - 1)) begin
      rowv_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      msp_d_reg   <= 1'b0;
      state_reg   <= ST_IDLE;
      row_reg     <= '0;
      col_reg     <= '0;
      cnt_reg     <= '0;
      global_reg  <= 1'b0;
      all_rst_reg <= 1'b1;
      sh_reg      <= 1'b1;
      rowv_reg    <= 1'b0;
    end else begin
      msp_d_reg   <= FRAME_START_PULSE_IN;
      state_reg   <= state_next;
      row_reg     <= row_next;
      col_reg     <= col_next;
      cnt_reg     <= cnt_next;
      global_reg  <= global_next;
      all_rst_reg <= all_rst_next;
      sh_reg      <= sh_next;
      rowv_reg    <= rowv_next;
    end
  end

  // video output register, popped when empty or taken
  assign pop = fifo_out_valid && (!vvalid_reg || VIDEO_READY_IN);
  always_comb begin
    vvalid_next = vvalid_reg;
    if (pop) begin
      vvalid_next = 1'b1;
    end else if (VIDEO_READY_IN) begin
      vvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      vvalid_reg <= 1'b0;
      vsig_reg   <= '0;
      vrst_reg   <= '0;
    end else begin
      vvalid_reg <= vvalid_next;
      if (pop) begin
        vsig_reg <= fifo_out_data[2*DW-1:DW];
        vrst_reg <= fifo_out_data[DW-1:0];
      end
    end
  end

  assign ROW_SEL_OUT                 = row_reg;
  assign ROW_SEL_VALID_OUT           = rowv_reg;
  assign COL_SEL_OUT                 = col_reg;
  assign SIG_HOLD_OUT                = (state_reg == ST_SIG);
  assign RST_HOLD_OUT                = (state_reg == ST_RHOLD);
  assign ROW_RESET_OUT               = (state_reg == ST_RST) || (state_reg == ST_RHOLD)
                                       || (state_reg == ST_SCAN);
  assign ALL_RESET_OUT               = all_rst_reg;
  assign PIXEL_SH_CLOSED_OUT         = sh_reg;
  assign GLOBAL_CAPTURE_OUT          = (state_reg == ST_GCAP);
  assign FRAME_BUSY_OUT              = (state_reg != ST_IDLE);
  assign VIDEO_VALID_OUT             = vvalid_reg;
  assign VIDEO_SIGNAL_OUT            = vsig_reg;
  assign VIDEO_RESET_OUT             = vrst_reg;
  assign CONVERTER_SAMPLE_STROBE_OUT = vvalid_reg && VIDEO_READY_IN;

  // helper: pixels pushed in the current row
  logic [CW:0] pcnt_reg;
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_reg <= '0;
    end else if (state_reg == ST_RHOLD) begin
      pcnt_reg <= '0;
    end else if (push) begin
      pcnt_reg <= pcnt_reg + (CW+1)'(1);
    end
  end

  rolling_sh_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (state_reg != ST_IDLE && !global_reg) |-> PIXEL_SH_CLOSED_OUT)
    else $error("sample-hold opened in rolling mode");
  row_step_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (state_reg == ST_SCAN && slot_tick && col_reg == CW'(COLS - 1) && row_reg != RW'(ROWS - 1))
    |=> (row_reg == $past(row_reg) + RW'(1)) && !ROW_RESET_OUT)
    else $error("row did not advance with reset release");
  hold_order_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    $rose(RST_HOLD_OUT) |-> $past(ROW_RESET_OUT) && !$past(SIG_HOLD_OUT))
    else $error("reset hold not after pixel reset");
  sig_then_rst_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    $fell(SIG_HOLD_OUT) |-> ROW_RESET_OUT && !RST_HOLD_OUT)
    else $error("signal capture not followed by pixel reset");
  slot_len_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (push && fifo_in_ready && col_reg != CW'(COLS - 1)) ##1 fifo_in_ready[*4] |-> push)
    else $error("pixel slot not four cycles");
  row_pixels_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (state_reg == ST_BLANK && $past(state_reg) == ST_SCAN) |-> pcnt_reg == (CW+1)'(COLS))
    else $error("row did not emit all columns");
  frame_start_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (state_reg == ST_IDLE && msp_rise) |=> row_reg == '0 && col_reg == '0 && FRAME_BUSY_OUT)
    else $error("frame did not restart at first row");
  global_cap_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (state_reg == ST_IDLE && msp_rise && mode_global_live) |=> GLOBAL_CAPTURE_OUT [*4] ##1 SIG_HOLD_OUT)
    else $error("global capture missing");
  global_rel_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (state_reg == ST_IDLE && mode_global_live && !FRAME_START_PULSE_IN) |=> !ALL_RESET_OUT)
    else $error("global reset not released");
  strobe_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
    (VIDEO_VALID_OUT && !CONVERTER_SAMPLE_STROBE_OUT)
    |=> VIDEO_VALID_OUT && $stable(VIDEO_SIGNAL_OUT) && $stable(VIDEO_RESET_OUT))
    else $error("video word changed before strobe");
endmodule

// ===== slot_divider.sv
// Purpose: one-cycle enable every DIV enabled cycles, giving the pixel slot rate
// Assumes: run low restarts the count
// Notes:   en low freezes the count so a stalled slot keeps its phase
`timescale 1ns/1ns
module slot_divider import scan_seq_pkg::*; #(
  parameter int DIV = SLOT_CYC
) (
  input  wire logic clk_in,   // core clock
  input  wire logic rst_n_in, // synchronised reset
  input  wire logic run_in,   // count while high
  input  wire logic en_in,    // advance enable
  output logic      tick_out  // last cycle of a slot
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  initial begin
    if (DIV < 1) $error("slot_divider: DIV must be at least 1");
  end

  assign tick_out = run_in && en_in && (cnt_reg == CW'(DIV - 1));

  always_comb begin
    cnt_next = cnt_reg;
    if (!run_in) begin
      cnt_next = '0;
    end else if (tick_out) begin
      cnt_next = '0;
    end else if (en_in) begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ===== testbench.sv
// Purpose: self-checking bench of the scan sequencer with a far side model
// Assumes: array cut to 4 rows of 16 columns to keep frames short
// Notes:   a monitor checks every video word, the scenario tasks check phase timing
`timescale 1ns/1ns
module testbench;
  import scan_seq_pkg::*;
  localparam int ROWS = 4;
  localparam int COLS = 16;
  logic clk = 1'b0, rst_n = 1'b0, pulse = 1'b0, mode1 = 1'b0, mode2 = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [11:0] pix_sig, pix_rst, vsig, vrst, offs;
  logic [1:0]  row;
  logic [3:0]  col;
  logic        rowv, sigh, rsth, rowr, allr, shc, gcap, busy, vval, vrdy, strobe;
  int          n_mismatch = 0, comparisons = 0, widx = 0, cyc = 0, last_cyc = 0;
  logic        mon_on = 1'b0, gap_chk = 1'b0, glob = 1'b0, prev_busy = 1'b0;
  logic [1:0]  prev_row = 2'h0;

  always #2 clk = ~clk;

  scan_sequencer #(.ROWS(ROWS), .COLS(COLS), .DW(PIX_DW), .DEPTH(FIFO_DEPTH)) i_dut (
    .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .FRAME_START_PULSE_IN(pulse), .MODE1_IN(mode1),
    .MODE2_IN(mode2), .PIX_SIGNAL_IN(pix_sig), .PIX_RESET_IN(pix_rst), .VIDEO_READY_IN(vrdy),
    .ROW_SEL_OUT(row), .ROW_SEL_VALID_OUT(rowv), .COL_SEL_OUT(col), .SIG_HOLD_OUT(sigh),
    .RST_HOLD_OUT(rsth), .ROW_RESET_OUT(rowr), .ALL_RESET_OUT(allr), .PIXEL_SH_CLOSED_OUT(shc),
    .GLOBAL_CAPTURE_OUT(gcap), .FRAME_BUSY_OUT(busy), .VIDEO_VALID_OUT(vval),
    .VIDEO_SIGNAL_OUT(vsig), .VIDEO_RESET_OUT(vrst), .CONVERTER_SAMPLE_STROBE_OUT(strobe));

  far_side_model #(.DW(PIX_DW), .RB(2), .CB(4)) i_far (
    .clk_in(clk), .rst_n_in(rst_n), .row_in(row), .row_valid_in(rowv), .col_in(col),
    .stall_in(stall), .slow_in(slow), .video_signal_in(vsig), .video_reset_in(vrst),
    .pix_signal_out(pix_sig), .pix_reset_out(pix_rst), .ready_out(vrdy), .offset_free_out(offs));

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  function automatic logic [11:0] exp_lvl(input logic [11:0] base, input int idx);
    return base + 12'((idx / COLS) * 16 + (idx % COLS));
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // every accepted word is checked against its row and column
  always @(posedge clk) begin
    if (mon_on) begin
      if (vval === 1'b1 && vrdy === 1'b1) begin
        chk_bit(strobe, 1'b1, "strobe on transfer");
        chk_word(vsig, exp_lvl(12'h500, widx), "signal word");
        chk_word(vrst, exp_lvl(12'h200, widx), "reset word");
        chk_word(offs, 12'h300, "offset removed");
        if (gap_chk && widx % COLS != 0) chk_num(cyc - last_cyc, SLOT_CYC, "slot length");
        last_cyc = cyc;
        widx++;
      end else begin
        chk_bit(strobe, 1'b0, "strobe idle");
      end
      if (prev_busy === 1'b1 && busy === 1'b1 && row !== prev_row) begin
        chk_bit(rowr, 1'b0, "row reset off at advance");
        chk_word({10'h0, row}, {10'h0, prev_row + 2'h1}, "row advance");
      end
      if (!glob) chk_bit(shc, 1'b1, "pixel hold closed");
    end
    prev_row  = row;
    prev_busy = busy;
    cyc++;
  end

  task automatic start_frame(input logic g);
    int k;
    widx = 0;
    @(posedge clk);
    pulse <= 1'b1;
    for (k = 0; k < 4 && busy !== 1'b1; k++) @(negedge clk);
    chk_bit(busy, 1'b1, "frame start");
    chk_word({10'h0, row}, 12'h0, "first row");
    chk_word({8'h0, col}, 12'h0, "first column");
    if (g) begin
      for (k = 0; k < 4; k++) begin
        chk_bit(gcap, 1'b1, "global capture");
        chk_bit(sigh, 1'b0, "no signal hold in capture");
        @(negedge clk);
      end
      chk_bit(shc, 1'b0, "pixel hold opened");
    end
    for (k = 0; k < 12; k++) begin
      chk_bit(sigh, k < 4, "signal hold phase");
      chk_bit(rowr, k >= 4, "row reset phase");
      chk_bit(rsth, k >= 8, "reset hold phase");
      chk_bit(gcap, 1'b0, "capture ended");
      @(negedge clk);
    end
  endtask

  task automatic end_frame();
    int k;
    for (k = 0; k < 20000 && (busy !== 1'b0 || widx < ROWS * COLS); k++) @(negedge clk);
    chk_num(widx, ROWS * COLS, "words per frame");
    chk_bit(busy, 1'b0, "frame ended");
    chk_bit(rowv, 1'b0, "row select off");
    chk_bit(vval, 1'b0, "buffer drained");
    @(posedge clk);
    pulse <= 1'b0;
    repeat (25) @(negedge clk);
  endtask

  task automatic test_reset();
    chk_bit(allr, 1'b1, "reset all-pixel reset");
    chk_bit(shc, 1'b1, "reset pixel hold");
    chk_bit(busy, 1'b0, "reset busy");
    chk_bit(vval, 1'b0, "reset video valid");
  endtask

  task automatic test_rolling();
    gap_chk = 1'b1;
    start_frame(1'b0);
    end_frame();
    gap_chk = 1'b0;
  endtask

  task automatic test_global();
    @(posedge clk);
    mode1 <= 1'b1;
    glob  <= 1'b1;
    repeat (25) @(negedge clk);
    chk_bit(allr, 1'b0, "pixel resets off while pulse low");
    start_frame(1'b1);
    chk_bit(allr, 1'b1, "pixel resets on after capture");
    end_frame();
    chk_bit(allr, 1'b0, "pixel resets off after frame");
    chk_bit(shc, 1'b1, "pixel hold closed again");
    @(posedge clk);
    mode1 <= 1'b0;
    glob  <= 1'b0;
  endtask

  task automatic test_stall_refuse();
    logic [3:0]  c0;
    logic [11:0] d0;
    @(posedge clk);
    mode2 <= 1'b1;
    stall <= 1'b1;
    start_frame(1'b0);
    @(posedge clk);
    pulse <= 1'b0;
    repeat (100) @(negedge clk);
    c0 = col;
    d0 = vsig;
    @(posedge clk);
    pulse <= 1'b1;
    repeat (20) @(negedge clk);
    chk_bit(vval, 1'b1, "word waits while stalled");
    chk_word(vsig, d0, "word stands while stalled");
    chk_word({8'h0, col}, {8'h0, c0}, "scan frozen on full buffer");
    chk_word({10'h0, row}, 12'h0, "rise in frame ignored");
    @(posedge clk);
    stall <= 1'b0;
    slow  <= 1'b1;
    end_frame();
    @(posedge clk);
    slow  <= 1'b0;
    mode2 <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    test_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    test_reset();
    mon_on = 1'b1;
    test_rolling();
    test_global();
    test_stall_refuse();
    test_rolling();
    test_done();
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    test_done();
  end
endmodule
